// ### verilog/ipl_pkg.sv
// package for the interrupt priority level registers
// holds register offsets, field positions, write masks, source count
// and the carrier struct that takes the resolved request to the core
package ipl_pkg;

   // ------------------------------------------------------------------
   // bus geometry
   // ------------------------------------------------------------------
   localparam int ADDR_W = 5;
   localparam int DATA_W = 16;
   localparam int NUM_SRC = 22;
   localparam int SRC_W = 5;

   // ------------------------------------------------------------------
   // register offsets (word addresses)
   // ------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_PRIO_ONE   = 5'h01;
   localparam logic [ADDR_W-1:0] OFS_PRIO_TWO   = 5'h02;
   localparam logic [ADDR_W-1:0] OFS_PRIO_THREE = 5'h03;
   localparam logic [ADDR_W-1:0] OFS_PRIO_FOUR  = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 5'h18;
   localparam logic [ADDR_W-1:0] OFS_EVT_MASK   = 5'h19;

   // ------------------------------------------------------------------
   // reset values and writable-bit masks; reserved bits stay zero
   // ------------------------------------------------------------------
   localparam logic [DATA_W-1:0] PRIO_RESET     = 16'h0000;
   localparam logic [DATA_W-1:0] WMASK_ONE      = 16'hC03F;
   localparam logic [DATA_W-1:0] WMASK_TWO      = 16'hC3FF;
   localparam logic [DATA_W-1:0] WMASK_THREE    = 16'hC03F;
   localparam logic [DATA_W-1:0] WMASK_FOUR     = 16'hFFFF;

   // ------------------------------------------------------------------
   // field low-bit positions, two bits each
   // ------------------------------------------------------------------
   localparam int LSB_PORT_D           = 14;
   localparam int LSB_FLASH_BUF_EMPTY  = 4;
   localparam int LSB_FLASH_CMD_DONE   = 2;
   localparam int LSB_FLASH_FAULT      = 0;
   localparam int LSB_ASYNC_TX_EMPTY   = 14;
   localparam int LSB_SYNC_TX_EMPTY    = 8;
   localparam int LSB_SYNC_RX_FULL     = 6;
   localparam int LSB_PORT_A           = 4;
   localparam int LSB_PORT_B           = 2;
   localparam int LSB_PORT_C           = 0;
   localparam int LSB_I2C_FAULT        = 14;
   localparam int LSB_ASYNC_RX_FULL    = 4;
   localparam int LSB_ASYNC_RX_FAULT   = 2;
   localparam int LSB_ASYNC_TX_IDLE    = 0;
   localparam int LSB_TIMER_CH3        = 14;
   localparam int LSB_TIMER_CH2        = 12;
   localparam int LSB_TIMER_CH1        = 10;
   localparam int LSB_TIMER_CH0        = 8;
   localparam int LSB_I2C_STATE        = 6;
   localparam int LSB_I2C_SEND         = 4;
   localparam int LSB_I2C_RECV         = 2;
   localparam int LSB_I2C_GEN_CALL     = 0;

   // ------------------------------------------------------------------
   // field codes
   // ------------------------------------------------------------------
   localparam logic [1:0] FIELD_OFF    = 2'h0;
   localparam logic [1:0] FIELD_LVL0   = 2'h1;
   localparam logic [1:0] FIELD_LVL1   = 2'h2;
   localparam logic [1:0] FIELD_LVL2   = 2'h3;

   // ------------------------------------------------------------------
   // event status bit positions
   // ------------------------------------------------------------------
   localparam int NUM_EVT      = 3;
   localparam int EVT_RAISED   = 0;
   localparam int EVT_DROPPED  = 1;
   localparam int EVT_PREEMPT  = 2;

   // resolved request handed to the core
   typedef struct packed {
      logic             valid;
      logic [1:0]       level;
      logic [SRC_W-1:0] source;
   } ipl_core_req_t;

endpackage : ipl_pkg

// ### verilog/ipl_field_dec.sv
// decoder for one two-bit priority field and its request line
// assumes the field value comes from a register in the same clock domain
`timescale 1ns/1ns
`default_nettype none
module ipl_field_dec
   import ipl_pkg::*;
(
   input  wire logic [1:0] field,
   input  wire logic       req,
   output logic            active,
   output logic [1:0]      level
);

   // 00 disables, 01..11 map onto levels 0..2; level 3 cannot be formed
   always_comb
   begin
      active = req && (field != FIELD_OFF);
      unique case (field)
         FIELD_LVL0: level = 2'h0;
         FIELD_LVL1: level = 2'h1;
         FIELD_LVL2: level = 2'h2;
         default:    level = 2'h0;
      endcase
   end

endmodule : ipl_field_dec
`default_nettype wire

// ### verilog/ipl_sticky_bit.sv
// one sticky status flag: hardware sets, software clears by writing one
// assumes set and clear are single-clock qualified pulses
`timescale 1ns/1ns
`default_nettype none
module ipl_sticky_bit
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic set,
   input  wire logic clr,
   output logic      q
);

   // a set in the clearing cycle wins so no event is lost
   always_ff @(posedge clk)
   begin
      if (rst)
         q <= 1'b0;
      else if (set)
         q <= 1'b1;
      else if (clr)
         q <= 1'b0;
   end

endmodule : ipl_sticky_bit
`default_nettype wire

// ### verilog/ipl_ctrl.sv
// priority level registers and request resolver of the interrupt controller
// assumes source request lines are levels synchronous to clk, and that the
// register port master never strobes read and write in the same cycle
`timescale 1ns/1ns
`default_nettype none

module ipl_ctrl
   import ipl_pkg::*;
(
   // clock, reset and register port
   input  wire logic              clk,
   input  wire logic              rst,

   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [DATA_W-1:0]      reg_rdata,

   // source request lines, by register
   input  wire logic              port_d_req,
   input  wire logic              flash_buffers_empty_req,
   input  wire logic              flash_cmd_done_req,
   input  wire logic              flash_fault_req,

   input  wire logic              async_tx_empty_req,
   input  wire logic              sync_tx_empty_req,
   input  wire logic              sync_rx_full_req,
   input  wire logic              port_a_req,
   input  wire logic              port_b_req,
   input  wire logic              port_c_req,

   input  wire logic              i2c_fault_req,
   input  wire logic              async_rx_full_req,
   input  wire logic              async_rx_fault_req,
   input  wire logic              async_tx_idle_req,

   input  wire logic              timer_ch3_req,
   input  wire logic              timer_ch2_req,
   input  wire logic              timer_ch1_req,
   input  wire logic              timer_ch0_req,
   input  wire logic              i2c_state_req,
   input  wire logic              i2c_send_req,
   input  wire logic              i2c_recv_req,
   input  wire logic              i2c_general_call_req,

   // toward the core
   output ipl_core_req_t          core_req,
   // level interrupt
   output logic                   irq
);

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   // register file
   logic [DATA_W-1:0]    priority_reg_one_r;
   logic [DATA_W-1:0]    priority_reg_two_r;
   logic [DATA_W-1:0]    priority_reg_three_r;
   logic [DATA_W-1:0]    priority_reg_four_r;
   logic [NUM_EVT-1:0]   evt_mask_r;

   // event flags
   logic [NUM_EVT-1:0]   evt_status;
   logic [NUM_EVT-1:0]   evt_set;
   logic [NUM_EVT-1:0]   evt_clr;

   // read path
   logic [DATA_W-1:0]    rdata_nxt;
   logic [DATA_W-1:0]    reg_rdata_r;

   // per-source request and level
   logic [NUM_SRC-1:0]   src_req;
   logic [NUM_SRC-1:0]   src_req_q_r;
   logic [2*NUM_SRC-1:0] src_field;
   logic [NUM_SRC-1:0]   src_active;
   logic [2*NUM_SRC-1:0] src_level;

   // winner and its copy
   logic                 pick_valid;
   logic [1:0]           pick_level;
   logic [SRC_W-1:0]     pick_source;
   ipl_core_req_t        core_req_r;

   // decoded write strobes
   logic                 wr_one;
   logic                 wr_two;
   logic                 wr_three;
   logic                 wr_four;
   logic                 wr_mask;
   logic                 wr_status;

   // ------------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------------
   // one decoded strobe per writable register
   assign wr_one    = reg_wr && (reg_addr == OFS_PRIO_ONE);
   assign wr_two    = reg_wr && (reg_addr == OFS_PRIO_TWO);
   assign wr_three  = reg_wr && (reg_addr == OFS_PRIO_THREE);
   assign wr_four   = reg_wr && (reg_addr == OFS_PRIO_FOUR);

   // event registers
   assign wr_mask   = reg_wr && (reg_addr == OFS_EVT_MASK);
   assign wr_status = reg_wr && (reg_addr == OFS_EVT_STATUS);

   // ------------------------------------------------------------------
   // priority registers
   // ------------------------------------------------------------------
   // reserved bits are masked on write, so a careless write cannot leave
   // nonzero junk that would read back later
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         // all sources off
         priority_reg_one_r   <= PRIO_RESET;
         priority_reg_two_r   <= PRIO_RESET;
         priority_reg_three_r <= PRIO_RESET;
         priority_reg_four_r  <= PRIO_RESET;
      end
      else
      begin
         if (wr_one)
            priority_reg_one_r <= reg_wdata & WMASK_ONE;

         if (wr_two)
            priority_reg_two_r <= reg_wdata & WMASK_TWO;

         if (wr_three)
            priority_reg_three_r <= reg_wdata & WMASK_THREE;

         // reg four has no reserved bits
         if (wr_four)
            priority_reg_four_r <= reg_wdata & WMASK_FOUR;
      end
   end

   // event mask register, same layout as the status register
   always_ff @(posedge clk)
   begin
      if (rst)
         evt_mask_r <= '0;
      else if (wr_mask)
         evt_mask_r <= reg_wdata[NUM_EVT-1:0];
   end

   // ------------------------------------------------------------------
   // read port
   // ------------------------------------------------------------------
   // unmapped offsets answer zero; narrow registers read zero above
   always_comb
   begin
      rdata_nxt = '0;

      unique case (reg_addr)
         OFS_PRIO_ONE:   rdata_nxt = priority_reg_one_r;
         OFS_PRIO_TWO:   rdata_nxt = priority_reg_two_r;
         OFS_PRIO_THREE: rdata_nxt = priority_reg_three_r;
         OFS_PRIO_FOUR:  rdata_nxt = priority_reg_four_r;
         // event registers fill the low bits
         OFS_EVT_STATUS: rdata_nxt[NUM_EVT-1:0] = evt_status;
         OFS_EVT_MASK:   rdata_nxt[NUM_EVT-1:0] = evt_mask_r;
         default:        rdata_nxt = '0;
      endcase
   end

   // data stand only in the cycle after the read strobe
   always_ff @(posedge clk)
   begin
      if (rst)
         reg_rdata_r <= '0;
      // read data for exactly one cycle
      else if (reg_rd)
         reg_rdata_r <= rdata_nxt;
      else
         reg_rdata_r <= '0;
   end

   assign reg_rdata = reg_rdata_r;

   // ------------------------------------------------------------------
   // source numbering and field extraction
   // ------------------------------------------------------------------
   // index order fixes the tie break: lower index wins at equal level
   assign src_req = {i2c_general_call_req, i2c_recv_req, i2c_send_req,
                     i2c_state_req, timer_ch0_req, timer_ch1_req,
                     timer_ch2_req, timer_ch3_req, async_tx_idle_req,
                     async_rx_fault_req, async_rx_full_req, i2c_fault_req,
                     port_c_req, port_b_req, port_a_req, sync_rx_full_req,
                     sync_tx_empty_req, async_tx_empty_req, flash_fault_req,
                     flash_cmd_done_req, flash_buffers_empty_req, port_d_req};

   // register one fields
   // port d: top field of reg one
   assign src_field[1:0]   = priority_reg_one_r[LSB_PORT_D +: 2];
   assign src_field[3:2]   = priority_reg_one_r[LSB_FLASH_BUF_EMPTY +: 2];
   assign src_field[5:4]   = priority_reg_one_r[LSB_FLASH_CMD_DONE +: 2];
   assign src_field[7:6]   = priority_reg_one_r[LSB_FLASH_FAULT +: 2];

   // register two fields
   assign src_field[9:8]   = priority_reg_two_r[LSB_ASYNC_TX_EMPTY +: 2];
   assign src_field[11:10] = priority_reg_two_r[LSB_SYNC_TX_EMPTY +: 2];
   assign src_field[13:12] = priority_reg_two_r[LSB_SYNC_RX_FULL +: 2];
   assign src_field[15:14] = priority_reg_two_r[LSB_PORT_A +: 2];
   assign src_field[17:16] = priority_reg_two_r[LSB_PORT_B +: 2];
   assign src_field[19:18] = priority_reg_two_r[LSB_PORT_C +: 2];

   // register three fields
   assign src_field[21:20] = priority_reg_three_r[LSB_I2C_FAULT +: 2];
   assign src_field[23:22] = priority_reg_three_r[LSB_ASYNC_RX_FULL +: 2];
   assign src_field[25:24] = priority_reg_three_r[LSB_ASYNC_RX_FAULT +: 2];
   assign src_field[27:26] = priority_reg_three_r[LSB_ASYNC_TX_IDLE +: 2];

   // register four fields
   assign src_field[29:28] = priority_reg_four_r[LSB_TIMER_CH3 +: 2];
   assign src_field[31:30] = priority_reg_four_r[LSB_TIMER_CH2 +: 2];
   assign src_field[33:32] = priority_reg_four_r[LSB_TIMER_CH1 +: 2];
   assign src_field[35:34] = priority_reg_four_r[LSB_TIMER_CH0 +: 2];
   assign src_field[37:36] = priority_reg_four_r[LSB_I2C_STATE +: 2];
   assign src_field[39:38] = priority_reg_four_r[LSB_I2C_SEND +: 2];
   assign src_field[41:40] = priority_reg_four_r[LSB_I2C_RECV +: 2];
   assign src_field[43:42] = priority_reg_four_r[LSB_I2C_GEN_CALL +: 2];

   // ------------------------------------------------------------------
   // per-source decode
   // ------------------------------------------------------------------
   // each decoder gates its request with the enable and maps the level
   for (genvar g = 0; g < NUM_SRC; g++)
   begin : g_dec
      // one decoder per source
      ipl_field_dec u_dec
      (
         .field  (src_field[2*g +: 2]),
         .req    (src_req[g]),
         .active (src_active[g]),
         .level  (src_level[2*g +: 2])
      );
   end

   // ------------------------------------------------------------------
   // priority resolution
   // ------------------------------------------------------------------
   // scan from the top index down so a strictly higher level replaces the
   // best, and an equal level from a lower index also replaces it
   always_comb
   begin
      pick_valid  = 1'b0;
      pick_level  = 2'h0;
      pick_source = '0;

      for (int i = NUM_SRC - 1; i >= 0; i--)
      begin
         // disabled sources never compete
         if (src_active[i] &&
             (!pick_valid || (src_level[2*i +: 2] >= pick_level)))
         begin
            // best so far
            pick_valid  = 1'b1;
            pick_level  = src_level[2*i +: 2];
            pick_source = SRC_W'(i);
         end
      end
   end

   // request to the core is registered; it follows the sources with one
   // cycle of latency, trading a cycle for a clean output
   always_ff @(posedge clk)
   begin
      if (rst)
         core_req_r <= '0;
      else
      begin
         // idle reads all zero
         core_req_r.valid  <= pick_valid;
         core_req_r.level  <= pick_valid ? pick_level : 2'h0;
         core_req_r.source <= pick_valid ? pick_source : '0;
      end
   end

   assign core_req = core_req_r;

   // ------------------------------------------------------------------
   // event detection
   // ------------------------------------------------------------------
   // previous request levels, for rising edges of the source lines
   always_ff @(posedge clk)
   begin
      if (rst)
         // a line held through reset rises
         src_req_q_r <= '0;
      else
         src_req_q_r <= src_req;
   end

   // raised: core request goes from idle to active
   // dropped: a disabled source raised its line and was ignored
   // preempt: a higher level takes over an outstanding request
   always_comb
   begin
      evt_set              = '0;

      evt_set[EVT_RAISED]  = pick_valid && !core_req_r.valid;
      evt_set[EVT_DROPPED] = |(src_req & ~src_req_q_r & ~src_active);
      evt_set[EVT_PREEMPT] = pick_valid && core_req_r.valid &&
                             (pick_level > core_req_r.level);
   end

   // write-one-to-clear on the status offset
   // zero bits leave their flags alone
   assign evt_clr = wr_status ? reg_wdata[NUM_EVT-1:0] : '0;

   // ------------------------------------------------------------------
   // status flags and interrupt output
   // ------------------------------------------------------------------
   for (genvar e = 0; e < NUM_EVT; e++)
   begin : g_evt
      // one flag per event
      ipl_sticky_bit u_flag
      (
         .clk (clk),
         .rst (rst),
         .set (evt_set[e]),
         .clr (evt_clr[e]),
         .q   (evt_status[e])
      );
   end

   // level output, high while any unmasked flag stands
   // masked flags still read back
   assign irq = |(evt_status & evt_mask_r);

endmodule : ipl_ctrl
`default_nettype wire

// ### verification/ipl_ctrl_chk.sv
// concurrent checks on the ports of the priority level register block
// assumes it is bound into ipl_ctrl and sees nothing but that module's ports
`timescale 1ns/1ns
`default_nettype none
module ipl_ctrl_chk
   import ipl_pkg::*;
(
   input wire logic              clk,
   input wire logic              rst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic              port_d_req,
   input wire ipl_core_req_t     core_req,
   input wire logic              irq
);
   // shadow of the port d field; source 0 wins every tie, so its outcome is certain
   logic [1:0] d_fld_r;
   always_ff @(posedge clk)
   begin
      if (rst)
         d_fld_r <= 2'h0;
      else if (reg_wr && reg_addr == OFS_PRIO_ONE)
         d_fld_r <= reg_wdata[15:14];
   end

   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   property p_reset_clear;
      $fell(rst) |-> core_req == '0 && !irq && reg_rdata == '0;
   endproperty
   a_reset_clear : assert property (p_reset_clear)
      else $error("outputs not clear after reset");

   property p_no_level3;
      core_req.valid |-> core_req.level != 2'h3;
   endproperty
   a_no_level3 : assert property (p_no_level3)
      else $error("level three forwarded");

   property p_res_one;
      $past(reg_rd) && $past(reg_addr) == OFS_PRIO_ONE |-> reg_rdata[13:6] == 8'h00;
   endproperty
   a_res_one : assert property (p_res_one)
      else $error("reserved bits of register one not zero");

   property p_res_two;
      $past(reg_rd) && $past(reg_addr) == OFS_PRIO_TWO |-> reg_rdata[13:10] == 4'h0;
   endproperty
   a_res_two : assert property (p_res_two)
      else $error("reserved bits of register two not zero");

   property p_res_three;
      $past(reg_rd) && $past(reg_addr) == OFS_PRIO_THREE |-> reg_rdata[13:6] == 8'h00;
   endproperty
   a_res_three : assert property (p_res_three)
      else $error("reserved bits of register three not zero");

   property p_rdback_four;
      reg_wr && reg_addr == OFS_PRIO_FOUR ##1 reg_rd && reg_addr == OFS_PRIO_FOUR
         |=> reg_rdata == $past(reg_wdata, 2);
   endproperty
   a_rdback_four : assert property (p_rdback_four)
      else $error("register four read back differs");

   property p_port_d_top;
      port_d_req && d_fld_r == 2'h3
         |=> core_req.valid && core_req.level == 2'h2 && core_req.source == 5'h00;
   endproperty
   a_port_d_top : assert property (p_port_d_top)
      else $error("top level source not forwarded");

   property p_mask_off;
      reg_wr && reg_addr == OFS_EVT_MASK && reg_wdata[2:0] == 3'h0 |=> !irq;
   endproperty
   a_mask_off : assert property (p_mask_off)
      else $error("interrupt high with all events masked");

   property p_rdata_idle;
      !$past(reg_rd) |-> reg_rdata == 16'h0000;
   endproperty
   a_rdata_idle : assert property (p_rdata_idle)
      else $error("read data outside the read cycle");
endmodule : ipl_ctrl_chk

bind ipl_ctrl ipl_ctrl_chk i_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .port_d_req(port_d_req), .core_req(core_req), .irq(irq));
`default_nettype wire

// ### verification/ipl_core_model.sv
// behavioural core that takes each forwarded request
// assumes requests are levels with no acknowledge, as the block presents them
`timescale 1ns/1ns
`default_nettype none
module ipl_core_model
   import ipl_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire ipl_core_req_t core_req,
   input  wire logic          irq,
   output logic [SRC_W-1:0]   last_src,
   output logic [1:0]         last_lvl,
   output logic               irq_seen
);
   // remember the last request taken; the core never stalls the block
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         last_src <= '0;
         last_lvl <= 2'h0;
         irq_seen <= 1'b0;
      end
      else
      begin
         if (core_req.valid)
         begin
            last_src <= core_req.source;
            last_lvl <= core_req.level;
         end
         irq_seen <= irq_seen | irq;
      end
   end
endmodule : ipl_core_model
`default_nettype wire

// ### verification/ipl_ctrl_bench.sv
// self-checking bench for the priority level register block
// assumes the design's register port and source lines are driven only from here
`timescale 1ns/1ns
`default_nettype none
module ipl_ctrl_bench
   import ipl_pkg::*;
;
   logic               clk;
   logic               rst;
   logic [ADDR_W-1:0]  reg_addr;
   logic [DATA_W-1:0]  reg_wdata;
   logic               reg_wr;
   logic               reg_rd;
   logic [DATA_W-1:0]  reg_rdata;
   logic [NUM_SRC-1:0] req_v;
   ipl_core_req_t      core_req;
   logic               irq;
   logic [SRC_W-1:0]   m_src;
   logic [1:0]         m_lvl;
   logic               m_irq;
   logic [DATA_W-1:0]  val;
   logic [DATA_W-1:0]  exp;
   int                 num_errors = 0;
   int                 checks = 0;
   int                 cycles = 0;
   // register and low bit of each source field, in source index order
   int ofs_t [NUM_SRC] = '{1,1,1,1,2,2,2,2,2,2,3,3,3,3,4,4,4,4,4,4,4,4};
   int lsb_t [NUM_SRC] = '{14,4,2,0,14,8,6,4,2,0,14,4,2,0,14,12,10,8,6,4,2,0};
   // all writable bits set, written as is; reserved bits go in clear and must come back clear
   logic [DATA_W-1:0] full_t [4] = '{16'hC03F, 16'hC3FF, 16'hC03F, 16'hFFFF};

   ipl_ctrl i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .port_d_req(req_v[0]), .flash_buffers_empty_req(req_v[1]),
      .flash_cmd_done_req(req_v[2]), .flash_fault_req(req_v[3]),
      .async_tx_empty_req(req_v[4]), .sync_tx_empty_req(req_v[5]),
      .sync_rx_full_req(req_v[6]), .port_a_req(req_v[7]), .port_b_req(req_v[8]),
      .port_c_req(req_v[9]), .i2c_fault_req(req_v[10]), .async_rx_full_req(req_v[11]),
      .async_rx_fault_req(req_v[12]), .async_tx_idle_req(req_v[13]),
      .timer_ch3_req(req_v[14]), .timer_ch2_req(req_v[15]), .timer_ch1_req(req_v[16]),
      .timer_ch0_req(req_v[17]), .i2c_state_req(req_v[18]), .i2c_send_req(req_v[19]),
      .i2c_recv_req(req_v[20]), .i2c_general_call_req(req_v[21]),
      .core_req(core_req), .irq(irq));

   ipl_core_model i_core (.clk(clk), .rst(rst), .core_req(core_req), .irq(irq),
      .last_src(m_src), .last_lvl(m_lvl), .irq_seen(m_irq));

   // ---------------------------------------------------------------
   // bus tasks
   // ---------------------------------------------------------------
   // one bus cycle; every strobe is set each call so none is driven twice a step
   task automatic acc(input logic w, input logic r, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
      reg_wr    <= w;
      reg_rd    <= r;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
   endtask : acc

   task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] want);
      checks++;
      if (got !== want)
      begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, want);
      end
   endtask : check

   // read data are taken in the cycle after the strobe, before that edge updates them
   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] want);
      acc(1'b0, 1'b1, a, 16'h0000);
      acc(1'b0, 1'b0, 5'h00, 16'h0000);
      check(reg_rdata, want);
   endtask : rdchk

   task automatic idle2();
      acc(1'b0, 1'b0, 5'h00, 16'h0000);
      acc(1'b0, 1'b0, 5'h00, 16'h0000);
   endtask : idle2

   task automatic end_of_test();
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // hang guard: the whole sequence needs well under a thousand cycles
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         num_errors++;
         end_of_test();
      end
   end

   // ---------------------------------------------------------------
   // test sequence
   // ---------------------------------------------------------------
   initial
   begin
      rst       <= 1'b1;
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
      reg_addr  <= '0;
      reg_wdata <= '0;
      req_v     <= '0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check({8'h00, core_req}, 16'h0000);
      for (int k = 1; k <= 4; k++)
         rdchk(5'(k), 16'h0000);
      // ones into every writable bit; reserved bits are written zero
      for (int k = 1; k <= 4; k++)
      begin
         acc(1'b1, 1'b0, 5'(k), full_t[k-1]);
         rdchk(5'(k), full_t[k-1]);
         acc(1'b1, 1'b0, 5'(k), 16'h0000);
      end
      acc(1'b1, 1'b0, 5'h05, 16'hFFFF);
      rdchk(5'h05, 16'h0000);
      // every code of every field, one source requesting at a time
      for (int i = 0; i < NUM_SRC; i++)
      begin
         for (int c = 0; c < 4; c++)
         begin
            val = 16'(c) << lsb_t[i];
            acc(1'b1, 1'b0, 5'(ofs_t[i]), val);
            req_v <= NUM_SRC'(1) << i;
            acc(1'b0, 1'b1, 5'(ofs_t[i]), 16'h0000);
            acc(1'b0, 1'b0, 5'h00, 16'h0000);
            check(reg_rdata, val);
            exp = (c == 0) ? 16'h0000 : {8'h00, 1'b1, 2'(c - 1), 5'(i)};
            check({8'h00, core_req}, exp);
         end
         req_v <= '0;
         acc(1'b1, 1'b0, 5'(ofs_t[i]), 16'h0000);
      end
      // flash fault at level 1, sync tx empty and timer ch0 at level 2
      acc(1'b1, 1'b0, OFS_EVT_STATUS, 16'h0007);
      acc(1'b1, 1'b0, OFS_PRIO_ONE, 16'h0002);
      acc(1'b1, 1'b0, OFS_PRIO_TWO, 16'h0300);
      acc(1'b1, 1'b0, OFS_PRIO_FOUR, 16'h0300);
      acc(1'b1, 1'b0, OFS_EVT_MASK, 16'h0007);
      req_v <= 22'h000008;
      idle2();
      check({8'h00, core_req}, {8'h00, 1'b1, 2'h1, 5'd3});
      rdchk(OFS_EVT_STATUS, 16'h0001);
      check({15'h0000, irq}, 16'h0001);
      req_v <= 22'h020028;
      idle2();
      check({8'h00, core_req}, {8'h00, 1'b1, 2'h2, 5'd5});
      rdchk(OFS_EVT_STATUS, 16'h0005);
      // core model lags an edge
      check({9'h000, m_lvl, m_src}, {9'h000, 2'h2, 5'd5});
      req_v <= 22'h020008;
      idle2();
      check({8'h00, core_req}, {8'h00, 1'b1, 2'h2, 5'd17});
      req_v <= '0;
      acc(1'b1, 1'b0, OFS_EVT_STATUS, 16'h0007);
      acc(1'b1, 1'b0, OFS_EVT_MASK, 16'h0000);
      // port d still holds code 00, so its request must be dropped
      req_v <= 22'h000001;
      idle2();
      check({8'h00, core_req}, 16'h0000);
      rdchk(OFS_EVT_STATUS, 16'h0002);
      check({15'h0000, irq}, 16'h0000);
      acc(1'b1, 1'b0, OFS_EVT_MASK, 16'h0002);
      acc(1'b0, 1'b0, 5'h00, 16'h0000);
      check({15'h0000, irq}, 16'h0001);
      acc(1'b1, 1'b0, OFS_EVT_STATUS, 16'h0002);
      acc(1'b0, 1'b0, 5'h00, 16'h0000);
      check({15'h0000, irq}, 16'h0000);
      check({15'h0000, m_irq}, 16'h0001);
      end_of_test();
   end
endmodule : ipl_ctrl_bench
`default_nettype wire
